// ---- bench/nv_storage_model.sv ----
`default_nettype none
`include "supervisor_regs.svh"

module nv_storage_model #(
    parameter logic [`NV_W-1:0] INIT = '0,
    parameter int               LAT  = 3
) (
    // clock
    input  wire logic             sys_clk,
    // load side
    input  wire logic             nv_load_req,
    output logic                  nv_load_valid,
    output logic [`NV_W-1:0]      nv_load_data,
    // store side
    input  wire logic             nv_store,
    input  wire logic [`NV_W-1:0] nv_store_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [`NV_W-1:0] mem       = INIT;
    int               cnt       = 0;
    int               store_cnt = 0;

    initial nv_load_valid = 1'b0;

    // idle bus shows inverted contents
    assign nv_load_data = nv_load_valid ? mem : ~mem;

    always @(posedge sys_clk) begin
        if (nv_load_valid) begin
            nv_load_valid <= 1'b0;
            cnt <= 0;
        end else if (nv_load_req) begin
            if (cnt == LAT) begin
                nv_load_valid <= 1'b1;
            end else begin
                cnt <= cnt + 1;
            end
        end else begin
            cnt <= 0;
        end
        if (nv_store) begin
            mem <= nv_store_data;
            store_cnt <= store_cnt + 1;
        end
    end
endmodule : nv_storage_model

`default_nettype wire

// ---- bench/output_alarm_supervisor_tb_top.sv ----
`default_nettype none
`include "supervisor_regs.svh"

module output_alarm_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, menu_open, status_view, nv_load_req, nv_load_valid, nv_store;
    logic output_enable, device_ready, ai_over_temp, ai_overvoltage;
    logic meas_valid = 0, over_temp = 0, share_bus_short = 0, share_bus_wired = 0;
    logic mains_fail = 0, power_switch_off = 0, local_lock = 0, fixed_safety_overvoltage_alarm_cmp = 0;
    logic panel_on_req = 0, panel_off_req = 0, panel_menu_req = 0;
    logic panel_menu_exit = 0, panel_take_local = 0;
    logic [`MEAS_W-1:0] meas_voltage = '0, meas_current = '0;
    logic [`NV_W-1:0] nv_load_data, nv_store_data;
    int error_cnt = 0, comparisons = 0;

    output_alarm_supervisor uut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .meas_valid, .meas_voltage, .meas_current, .over_temp,
        .fixed_safety_overvoltage_alarm_cmp, .share_bus_short, .share_bus_wired, .mains_fail, .power_switch_off,
        .local_lock, .panel_on_req, .panel_off_req, .panel_menu_req, .panel_menu_exit,
        .panel_take_local, .menu_open, .status_view, .nv_load_req, .nv_load_valid,
        .nv_load_data, .nv_store, .nv_store_data, .output_enable, .device_ready,
        .ai_over_temp, .ai_overvoltage);

    nv_storage_model #(.INIT({1'b0, 4'h0, 32'hFFFFFFFF, 16'hFFFF, 16'h0FFF})) nv_mem (
        .sys_clk, .nv_load_req, .nv_load_valid, .nv_load_data, .nv_store, .nv_store_data);

    initial forever #50 sys_clk = ~sys_clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task summarize;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task smp(input logic [15:0] v, input logic [15:0] i);
        @(posedge sys_clk);
        meas_valid <= 1'b1;
        meas_voltage <= v;
        meas_current <= i;
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        @(negedge sys_clk);
    endtask : smp

    task panel(input logic [2:0] p);
        @(posedge sys_clk) {panel_take_local, panel_menu_req, panel_menu_exit} <= p;
        @(posedge sys_clk) {panel_take_local, panel_menu_req, panel_menu_exit} <= 3'b000;
        repeat (2) @(negedge sys_clk);
    endtask : panel

    task stat(input logic [6:0] a);
        xfer(0, `SUP_STATUS_OFS, 0);
        chk(r[6:0], a);
    endtask : stat

    task boot;
        int n;
        n = 0;
        while (device_ready !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (2) @(negedge sys_clk);
        chk(device_ready, 1);
        chk(nv_load_req, 0);
    endtask : boot

    task trip(input logic [15:0] v, input logic [15:0] i, input logic [6:0] a);
        smp(v, i);
        chk({output_enable, ai_overvoltage}, {1'b0, a[1]});
        xfer(1, `SUP_CTRL_OFS, 32'h0F);
        repeat (2) @(negedge sys_clk);
        chk(output_enable, 0);
        stat(a);
        xfer(1, `SUP_ACK_OFS, {25'h0, a});
        stat(7'h00);
        xfer(1, `SUP_CTRL_OFS, 32'h0F);
        repeat (2) @(negedge sys_clk);
        chk(output_enable, 1);
    endtask : trip

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        chk(nv_load_req, 1);
        srst <= 1'b0;
        boot();
        chk(output_enable, 0);
        xfer(0, `SUP_OVP_THR_OFS, 0);
        chk(r, 32'h0FFF);
        xfer(0, 8'h18, 0);
        chk(e, 1);
        chk(r, 32'h0);
        xfer(1, `SUP_OCP_LIM_OFS, 32'h0100);
        xfer(1, `SUP_CTRL_OFS, 32'h0F);
        smp(16'h0FFF, 16'h00FF);
        chk(output_enable, 1);
        trip(16'h1000, 16'h0000, 7'h02);
        xfer(0, 8'h24, 0);
        chk(r, 1);
        trip(16'h0000, 16'h0100, 7'h04);
        xfer(1, `SUP_OPP_LIM_OFS, 32'h1000);
        trip(16'h0100, 16'h0010, 7'h08);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk) {mains_fail, over_temp} <= k ? 2'b10 : 2'b01;
            repeat (3) @(negedge sys_clk);
            chk({output_enable, ai_over_temp}, k ? 2'b00 : 2'b01);
            @(posedge sys_clk) {mains_fail, over_temp} <= 2'b00;
            repeat (3) @(negedge sys_clk);
            chk(output_enable, 1);
            stat(k ? 7'h40 : 7'h01);
            xfer(1, `SUP_ACK_OFS, 32'h41);
            stat(7'h00);
            @(posedge sys_clk) {share_bus_wired, share_bus_short} <= k ? 2'b10 : 2'b01;
            repeat (3) @(negedge sys_clk);
            chk(output_enable, 0);
            xfer(1, `SUP_ACK_OFS, 32'h20);
            stat(7'h20);
            @(posedge sys_clk) {share_bus_wired, share_bus_short} <= 2'b00;
            xfer(1, `SUP_ACK_OFS, 32'h20);
            stat(7'h00);
            xfer(1, `SUP_CTRL_OFS, 32'h0F);
        end
        panel(3'b100);
        panel(3'b010);
        chk({menu_open, status_view}, 2'b01);
        panel(3'b001);
        xfer(1, `SUP_CTRL_OFS, 32'h0E);
        xfer(0, `SUP_STATUS_OFS, 0);
        chk(r[10], 1);
        panel(3'b100);
        panel(3'b010);
        chk({menu_open, status_view}, 2'b10);
        panel(3'b001);
        @(posedge sys_clk) panel_on_req <= 1'b1;
        @(posedge sys_clk) panel_on_req <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(output_enable, 1);
        @(posedge sys_clk) local_lock <= 1'b1;
        xfer(1, `SUP_CTRL_OFS, 32'h0E);
        repeat (2) @(negedge sys_clk);
        chk(output_enable, 1);
        @(posedge sys_clk) local_lock <= 1'b0;
        xfer(1, `SUP_CTRL_OFS, 32'h0F);
        @(posedge sys_clk) power_switch_off <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({output_enable, nv_mem.mem[68], nv_mem.mem[15:0]}, 18'h10FFF);
        chk(nv_mem.store_cnt, 1);
        stat(7'h40);
        @(posedge sys_clk) srst <= 1'b1;
        power_switch_off <= 1'b0;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        boot();
        chk(output_enable, 1);
        xfer(0, `SUP_CTRL_OFS, 0);
        chk(r[4:0], 5'h0F);
        stat(7'h00);
        xfer(1, `SUP_CTRL_OFS, 32'h0D);
        @(posedge sys_clk) over_temp <= 1'b1;
        @(posedge sys_clk) over_temp <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(output_enable, 0);
        xfer(1, `SUP_ACK_OFS, 32'h01);
        xfer(1, `SUP_CTRL_OFS, 32'h0D);
        xfer(1, `SUP_OVP_THR_OFS, 32'hFFFF);
        xfer(0, `SUP_OVP_THR_OFS, 0);
        chk(r, 32'h19C8);
        smp(16'h17AC, 16'h0000);
        chk(output_enable, 0);
        xfer(1, `SUP_ACK_OFS, 32'h7F);
        stat(7'h10);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
endmodule : output_alarm_supervisor_tb_top

`default_nettype wire

// ---- logic/alarm_cnt_if.sv ----
`default_nettype none
`include "supervisor_regs.svh"

interface alarm_cnt_if;
    logic [`ALARM_N-1:0] hit;
    logic [2:0]          sel;
    logic [`CNT_W-1:0]   count;

    modport src  (output hit, output sel, input count);
    modport bank (input hit, input sel, output count);
endinterface : alarm_cnt_if

`default_nettype wire

// ---- logic/alarm_counter_bank.sv ----
`default_nettype none
`include "supervisor_regs.svh"

module alarm_counter_bank
    import supervisor_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   srst,
    // events in, count out
    alarm_cnt_if.bank   cnt_if
);

    cnt_state_t                           st_ff;
    cnt_state_t                           nxt_st;
    logic [`ALARM_N-1:0][`CNT_W-1:0]      inc_val;

    // ----------------------------------------
    // saturating increment per alarm
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `ALARM_N; gi++) begin : g_cnt
            assign inc_val[gi] = (cnt_if.hit[gi] && st_ff.cnt[gi] != {`CNT_W{1'b1}}) ?
                                 st_ff.cnt[gi] + `CNT_W'(1) : st_ff.cnt[gi];
        end
    endgenerate

    always_comb begin
        nxt_st.cnt = inc_val;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cnt_if.count = (cnt_if.sel < 3'(`ALARM_N)) ? st_ff.cnt[cnt_if.sel] : '0;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_count_step: assert property (@(posedge sys_clk) disable iff (srst)
        (cnt_if.hit[0] && st_ff.cnt[0] != {`CNT_W{1'b1}}) |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + `CNT_W'(1))
        else $error("alarm counter did not step");

endmodule : alarm_counter_bank

`default_nettype wire

// ---- logic/output_alarm_supervisor.sv ----
`default_nettype none
`include "supervisor_regs.svh"

module output_alarm_supervisor
    import supervisor_pkg::*;
#(
    parameter logic [`MEAS_W-1:0] NOMINAL_V      = 16'h1770,
    parameter bit                 HAS_FIXED_SAFETY_OVERVOLTAGE_ALARM = 1'b1
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // measurements from the power stage
    input  wire logic                  meas_valid,
    input  wire logic [`MEAS_W-1:0]    meas_voltage,
    input  wire logic [`MEAS_W-1:0]    meas_current,
    input  wire logic                  over_temp,
    input  wire logic                  fixed_safety_overvoltage_alarm_cmp,
    input  wire logic                  share_bus_short,
    input  wire logic                  share_bus_wired,
    input  wire logic                  mains_fail,
    input  wire logic                  power_switch_off,
    // front panel
    input  wire logic                  local_lock,
    input  wire logic                  panel_on_req,
    input  wire logic                  panel_off_req,
    input  wire logic                  panel_menu_req,
    input  wire logic                  panel_menu_exit,
    input  wire logic                  panel_take_local,
    output logic                       menu_open,
    output logic                       status_view,
    // non-volatile storage
    output logic                       nv_load_req,
    input  wire logic                  nv_load_valid,
    input  wire logic [`NV_W-1:0]      nv_load_data,
    output logic                       nv_store,
    output logic [`NV_W-1:0]           nv_store_data,
    // power stage and analogue interface
    output logic                       output_enable,
    output logic                       device_ready,
    output logic                       ai_over_temp,
    output logic                       ai_overvoltage
);

    localparam logic [`MEAS_W-1:0] OVP_MAX = `MEAS_W'((32'(NOMINAL_V) * `OVP_MAX_PERCENT) / 100);

    sup_state_t               st_ff;
    sup_state_t               nxt_st;
    alarm_cnt_if              cnt_bus ();

    logic                     apb_wr;
    logic                     apb_setup;
    logic                     mapped;
    logic                     wr_ok;
    logic [`ALARM_N-1:0]      trip;
    logic [`ALARM_N-1:0]      ack;
    logic [2*`MEAS_W-1:0]     power;
    logic                     sample;
    logic                     kill;
    logic                     on_req;
    logic                     off_req;
    logic [`MEAS_W-1:0]       wr_ovp;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    always_comb begin
        mapped = (paddr[1:0] == 2'b00) &&
                 (paddr <= `SUP_ACK_OFS ||
                  (paddr >= `SUP_CNT_BASE_OFS && paddr <= `SUP_CNT_LAST_OFS));
    end

    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite && mapped;
    assign wr_ok     = apb_wr && !local_lock;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign cnt_bus.sel = 3'(paddr[4:2]);

    // ----------------------------------------
    // trip detection
    // ----------------------------------------
    assign power  = 32'(meas_voltage) * 32'(meas_current);
    assign sample = meas_valid && st_ff.phase == PH_RUN;
    assign wr_ovp = (pwdata[`MEAS_W-1:0] > OVP_MAX) ? OVP_MAX : pwdata[`MEAS_W-1:0];

    always_comb begin
        trip = '0;
        trip[`ALM_OT]   = over_temp && !st_ff.ot_q;
        // terminal voltage, whatever drives it
        trip[`ALM_OV]   = sample && meas_voltage > st_ff.ovp_thr;
        trip[`ALM_OC]   = sample && meas_current >= st_ff.ocp_lim;
        trip[`ALM_OP]   = sample && power >= st_ff.opp_lim;
        trip[`ALM_SAFE] = HAS_FIXED_SAFETY_OVERVOLTAGE_ALARM &&
                          (fixed_safety_overvoltage_alarm_cmp || (meas_valid && meas_voltage >= `FIXED_SAFETY_OVERVOLTAGE_ALARM_CODE));
        trip[`ALM_SF]   = st_ff.phase == PH_RUN &&
                          (share_bus_short || (share_bus_wired && !st_ff.cfg[`CTRL_PARALLEL_BIT-1]));
        trip[`ALM_PF]   = (mains_fail && !st_ff.mains_q) || (power_switch_off && !st_ff.sw_q);
    end

    always_comb begin
        ack = '0;
        if (wr_ok && paddr == `SUP_ACK_OFS) begin
            ack = pwdata[`ALARM_N-1:0];
        end
        ack[`ALM_SAFE] = 1'b0;
    end

    assign kill = |trip[`ALM_SF:`ALM_OV] || (power_switch_off && !st_ff.sw_q);

    always_comb begin
        on_req  = 1'b0;
        off_req = 1'b0;
        if (wr_ok && paddr == `SUP_CTRL_OFS) begin
            on_req  = pwdata[`CTRL_OUT_ON_BIT];
            off_req = !pwdata[`CTRL_OUT_ON_BIT];
        end else if (!st_ff.remote) begin
            on_req  = panel_on_req;
            off_req = panel_off_req;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.ot_q     = over_temp;
        nxt_st.mains_q  = mains_fail;
        nxt_st.sw_q     = power_switch_off;
        nxt_st.nv_store = 1'b0;
        nxt_st.alarm    = (st_ff.alarm & ~ack) | trip;
        if (apb_setup) begin
            case (paddr)
                `SUP_CTRL_OFS:    nxt_st.prdata = {27'h0, st_ff.cfg, st_ff.out_req};
                `SUP_OVP_THR_OFS: nxt_st.prdata = {16'h0, st_ff.ovp_thr};
                `SUP_OCP_LIM_OFS: nxt_st.prdata = {16'h0, st_ff.ocp_lim};
                `SUP_OPP_LIM_OFS: nxt_st.prdata = st_ff.opp_lim;
                `SUP_STATUS_OFS:  nxt_st.prdata = {19'h0, st_ff.status_view, st_ff.menu, st_ff.remote,
                                                   st_ff.phase == PH_RUN, st_ff.out_en, 1'b0,
                                                   st_ff.alarm};
                default:          nxt_st.prdata = (mapped && paddr >= `SUP_CNT_BASE_OFS) ?
                                                  {16'h0, cnt_bus.count} : 32'h0;
            endcase
        end
        if (apb_wr && !local_lock) begin
            nxt_st.remote = 1'b1;
        end else if (panel_take_local) begin
            nxt_st.remote = 1'b0;
        end
        case (st_ff.phase)
            PH_LOAD: begin
                if (nv_load_valid) begin
                    nxt_st.ovp_thr = nv_load_data[15:0];
                    nxt_st.ocp_lim = nv_load_data[31:16];
                    nxt_st.opp_lim = nv_load_data[63:32];
                    nxt_st.cfg     = nv_load_data[67:64];
                    nxt_st.out_req = nv_load_data[68] && nv_load_data[64+`CTRL_PWR_ON_BIT-1];
                    nxt_st.phase   = PH_RUN;
                end
            end
            PH_RUN: begin
                if (wr_ok) begin
                    case (paddr)
                        `SUP_CTRL_OFS:    nxt_st.cfg     = pwdata[`CTRL_PARALLEL_BIT:`CTRL_POST_OT_BIT];
                        `SUP_OVP_THR_OFS: nxt_st.ovp_thr = wr_ovp;
                        `SUP_OCP_LIM_OFS: nxt_st.ocp_lim = pwdata[`MEAS_W-1:0];
                        `SUP_OPP_LIM_OFS: nxt_st.opp_lim = pwdata;
                        default: ;
                    endcase
                end
                if (off_req) begin
                    nxt_st.out_req = 1'b0;
                end else if (on_req && st_ff.alarm == '0 && trip == '0) begin
                    nxt_st.out_req = 1'b1;
                end
                if (trip[`ALM_OT] && !st_ff.cfg[`CTRL_POST_OT_BIT-1]) begin
                    nxt_st.out_req = 1'b0;
                end
                if (mains_fail && !st_ff.mains_q && !st_ff.cfg[`CTRL_POST_PF_BIT-1]) begin
                    nxt_st.out_req = 1'b0;
                end
                if (kill) begin
                    nxt_st.out_req = 1'b0;
                end
                if (power_switch_off && !st_ff.sw_q) begin
                    nxt_st.nv_store = 1'b1;
                    nxt_st.nv_data  = {st_ff.out_req, st_ff.cfg, st_ff.opp_lim, st_ff.ocp_lim, st_ff.ovp_thr};
                    nxt_st.phase    = PH_DOWN;
                end
            end
            PH_DOWN: begin
                nxt_st.out_req = 1'b0;
            end
            default: begin
                nxt_st.phase = PH_LOAD;
            end
        endcase
        // disable lands with the latch edge
        nxt_st.out_en = nxt_st.out_req && nxt_st.phase == PH_RUN && !over_temp && !mains_fail &&
                        !kill && !nxt_st.alarm[`ALM_SAFE];
        if (panel_menu_exit || nxt_st.out_en) begin
            nxt_st.menu = 1'b0;
        end
        if (panel_menu_exit || !nxt_st.out_en) begin
            nxt_st.status_view = 1'b0;
        end
        if (panel_menu_req && !st_ff.remote) begin
            nxt_st.menu        = !st_ff.out_en && !nxt_st.out_en;
            nxt_st.status_view = st_ff.out_en && nxt_st.out_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff         <= '0;
            st_ff.phase   <= PH_LOAD;
            st_ff.cfg     <= `CFG_RST;
            st_ff.ovp_thr <= `OVP_THR_RST;
            st_ff.ocp_lim <= `OCP_LIM_RST;
            st_ff.opp_lim <= `OPP_LIM_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // counters and outputs
    // ----------------------------------------
    assign cnt_bus.hit = nxt_st.alarm & ~st_ff.alarm;

    alarm_counter_bank u_counters (
        .sys_clk (sys_clk),
        .srst    (srst),
        .cnt_if  (cnt_bus)
    );

    assign prdata         = st_ff.prdata;
    assign output_enable  = st_ff.out_en;
    assign device_ready   = st_ff.phase == PH_RUN;
    assign nv_load_req    = st_ff.phase == PH_LOAD;
    assign nv_store       = st_ff.nv_store;
    assign nv_store_data  = st_ff.nv_data;
    assign menu_open      = st_ff.menu;
    assign status_view    = st_ff.status_view;
    assign ai_over_temp   = st_ff.alarm[`ALM_OT];
    assign ai_overvoltage = st_ff.alarm[`ALM_OV];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ot_disable: assert property (@(posedge sys_clk) disable iff (srst)
        (over_temp && !st_ff.ot_q) |=> st_ff.alarm[`ALM_OT] && !output_enable)
        else $error("over-temperature did not disable output");
    a_ot_no_restore: assert property (@(posedge sys_clk) disable iff (srst)
        (st_ff.alarm[`ALM_OT] && !st_ff.cfg[`CTRL_POST_OT_BIT-1]) |-> !output_enable)
        else $error("output back on after over-temperature");
    a_ovp_trip: assert property (@(posedge sys_clk) disable iff (srst)
        (sample && meas_voltage > st_ff.ovp_thr) |=> st_ff.alarm[`ALM_OV] && !output_enable)
        else $error("overvoltage not latched");
    a_ocp_trip: assert property (@(posedge sys_clk) disable iff (srst)
        (sample && meas_current >= st_ff.ocp_lim) |=> st_ff.alarm[`ALM_OC] && !output_enable)
        else $error("overcurrent not latched");
    a_opp_trip: assert property (@(posedge sys_clk) disable iff (srst)
        (sample && power >= st_ff.opp_lim) |=> st_ff.alarm[`ALM_OP] && !output_enable)
        else $error("overpower not latched");
    a_safety_hold: assert property (@(posedge sys_clk) disable iff (srst)
        st_ff.alarm[`ALM_SAFE] |=> st_ff.alarm[`ALM_SAFE] && !output_enable)
        else $error("safety alarm released");
    a_share_trip: assert property (@(posedge sys_clk) disable iff (srst)
        (st_ff.phase == PH_RUN && share_bus_short) |=> st_ff.alarm[`ALM_SF] && !output_enable)
        else $error("share bus fault not latched");
    a_switch_off: assert property (@(posedge sys_clk) disable iff (srst)
        (st_ff.phase == PH_RUN && $rose(power_switch_off)) |=>
        nv_store && !output_enable && st_ff.alarm[`ALM_PF] && nv_store_data[68] == $past(st_ff.out_req))
        else $error("switch-off not handled");
    a_boot_off: assert property (@(posedge sys_clk) disable iff (srst)
        !device_ready |-> !output_enable)
        else $error("output on before ready");
    a_menu_gate: assert property (@(posedge sys_clk) disable iff (srst)
        menu_open |-> !output_enable)
        else $error("menu open with output on");

    c_ot_trip:  cover property (@(posedge sys_clk) disable iff (srst) $rose(st_ff.alarm[`ALM_OT]));
    c_restore:  cover property (@(posedge sys_clk) disable iff (srst)
        st_ff.alarm[`ALM_OT] && $rose(output_enable));
    c_store:    cover property (@(posedge sys_clk) disable iff (srst) nv_store);
    c_remote:   cover property (@(posedge sys_clk) disable iff (srst) $rose(st_ff.remote));

endmodule : output_alarm_supervisor

`default_nettype wire

// ---- logic/supervisor_pkg.sv ----
`default_nettype none
`include "supervisor_regs.svh"

package supervisor_pkg;

    typedef enum logic [1:0] {
        PH_LOAD,
        PH_RUN,
        PH_DOWN
    } phase_t;

    typedef struct packed {
        phase_t                   phase;
        logic [`ALARM_N-1:0]      alarm;
        logic                     out_req;
        logic                     out_en;
        logic [3:0]               cfg;
        logic [`MEAS_W-1:0]       ovp_thr;
        logic [`MEAS_W-1:0]       ocp_lim;
        logic [2*`MEAS_W-1:0]     opp_lim;
        logic                     remote;
        logic                     menu;
        logic                     status_view;
        logic                     ot_q;
        logic                     mains_q;
        logic                     sw_q;
        logic                     nv_store;
        logic [`NV_W-1:0]         nv_data;
        logic [31:0]              prdata;
    } sup_state_t;

    typedef struct packed {
        logic [`ALARM_N-1:0][`CNT_W-1:0] cnt;
    } cnt_state_t;

endpackage : supervisor_pkg

`default_nettype wire

// ---- logic/supervisor_regs.svh ----
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SUP_CTRL_OFS      8'h00
`define SUP_OVP_THR_OFS   8'h04
`define SUP_OCP_LIM_OFS   8'h08
`define SUP_OPP_LIM_OFS   8'h0C
`define SUP_STATUS_OFS    8'h10
`define SUP_ACK_OFS       8'h14
`define SUP_CNT_BASE_OFS  8'h20
`define SUP_CNT_LAST_OFS  8'h38

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_OUT_ON_BIT       0
`define CTRL_POST_OT_BIT      1
`define CTRL_POST_PF_BIT      2
`define CTRL_PWR_ON_BIT       3
`define CTRL_PARALLEL_BIT     4

// ----------------------------------------
// alarm bit positions (status, ack, counters)
// ----------------------------------------
`define ALM_OT      0
`define ALM_OV      1
`define ALM_OC      2
`define ALM_OP      3
`define ALM_SAFE    4
`define ALM_SF      5
`define ALM_PF      6
`define ALARM_N     7

// ----------------------------------------
// status register fields above the alarms
// ----------------------------------------
`define STAT_OUT_EN_BIT   8
`define STAT_READY_BIT    9
`define STAT_REMOTE_BIT   10
`define STAT_MENU_BIT     11
`define STAT_VIEW_BIT     12

// ----------------------------------------
// widths, reset values, fixed levels
// ----------------------------------------
`define MEAS_W            16
`define CNT_W             16
`define NV_W              69
`define OVP_THR_RST       16'h0000
`define OCP_LIM_RST       16'hFFFF
`define OPP_LIM_RST       32'hFFFFFFFF
`define CFG_RST           4'h0
// voltage in 10 mV units: 60.6 V
`define FIXED_SAFETY_OVERVOLTAGE_ALARM_CODE   16'h17AC
`define OVP_MAX_PERCENT   110

`endif
